// ==== src/mm_link_defs.svh ====
// Constants for the memory-mapped transfer link
`ifndef MM_LINK_DEFS_SVH
`define MM_LINK_DEFS_SVH
`define DATA_W       32
`define BE_W         4
`define ADDR_W       8
`define MEM_DEPTH    256
`define BE_ALL       4'hf
`define BE_LOW2      4'h3
`define BE_HIGH2     4'hc
`define BE_B0        4'h1
`define BE_B1        4'h2
`define BE_B2        4'h4
`define BE_B3        4'h8
`define BE_NONE      4'h0
`define RESP_OK      2'h0
`define RESP_RSVD    2'h1
`define RESP_SLVERR  2'h2
`define RESP_DECERR  2'h3
`define BURST_W      8
`define BURST_ONE    8'h01
`define ROM_BASE     8'hc0
`define MAP_TOP      8'hf0
`endif

// ==== src/mm_link_pkg.sv ====
// Types shared by both ends of the transfer link
`include "mm_link_defs.svh"
package mm_link_pkg;
    typedef logic [1:0] resp_t;
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_READ  = 2'b01,
        S_WRITE = 2'b10,
        S_WRESP = 2'b11
    } slv_state_t;
    typedef enum logic [1:0] {
        M_IDLE  = 2'b00,
        M_RWAIT = 2'b01,
        M_WWAIT = 2'b10
    } mst_state_t;
endpackage

// ==== src/mm_link_if.sv ====
// Interface joining the requesting end and the memory end
`include "mm_link_defs.svh"
interface mm_link_if;
    logic                  read;
    logic                  write;
    logic [`ADDR_W-1:0]    address;
    logic [`BURST_W-1:0]   burstCount;
    logic [`BE_W-1:0]      byteEnable;
    logic [`DATA_W-1:0]    writeData;
    logic                  debugAccess;
    logic                  waitRequest;
    logic [`DATA_W-1:0]    readData;
    logic                  readDataValid;
    logic                  writeResponseValid;
    logic [1:0]            response;
    modport master (output read, write, address, burstCount, byteEnable, writeData, debugAccess,
                    input waitRequest, readData, readDataValid, writeResponseValid, response);
    modport slave  (input read, write, address, burstCount, byteEnable, writeData, debugAccess,
                    output waitRequest, readData, readDataValid, writeResponseValid, response);
endinterface

// ==== src/mm_memory_slave.sv ====
// Memory end: word memory with byte lanes, read bursts and write responses
`include "mm_link_defs.svh"
// What this block does
// - Contiguous aligned lane patterns write matching bytes
// - One-hot lane pattern writes exactly one byte
// - Master drives lane enables in mixed widths
// - Master passes any nonzero lane pattern through, zero becomes all lanes; unaligned ones get a slave error
// - Debug access lets writes reach read-only area
// - Read strobe marks read, carries read data
// - Slave drives read data answering reads
// - Response codes success, endpoint error, undefined
// - Never read and write response together
// - One response per returned read word
// - Each burst word may carry own status
// - Read responses qualified by read-data-valid
// - Master ignores read data on error
// - Write responses qualified by write-response-valid
// - One write response after final burst beat
// - Every write command gets a response
// - Write strobe marks write, carries write data
// - Active-low variants end in _n
// - Lane n governs byte n of data
module mm_memory_slave
    import mm_link_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    sys_rst,
    mm_link_if.slave     bus
);
    ////////////////////////////////////////////////////////////////////
    logic [`DATA_W-1:0]  mem [`MEM_DEPTH];
    slv_state_t          state,      next_state;
    logic [`ADDR_W-1:0]  addr,       next_addr;
    logic [`BURST_W-1:0] left,       next_left;
    resp_t               wStatus,    next_wStatus;
    logic [`DATA_W-1:0]  rData,      next_rData;
    logic                rValid,     next_rValid;
    logic                wValid,     next_wValid;
    resp_t               resp,       next_resp;
    logic                memWe;
    logic [`DATA_W-1:0]  memWord;
    logic                legalBe;
    logic                mapped;
    logic                romHit;
    logic [`ADDR_W-1:0]  beatAddr;
    logic [`BURST_W-1:0] beats;
    resp_t               beatStatus;
    logic                beatOk;

    ////////////////////////////////////////////////////////////////////
    // Lane patterns the memory accepts
    always_comb begin
        case (bus.byteEnable)
            `BE_ALL, `BE_LOW2, `BE_HIGH2: legalBe = 1'b1;
            `BE_B0, `BE_B1, `BE_B2, `BE_B3: legalBe = 1'b1;
            default: legalBe = 1'b0;
        endcase
    end

    // Command cycle takes its address from the bus, later beats from the counter
    assign beatAddr = (state == S_IDLE) ? bus.address : addr;
    assign beats    = (bus.burstCount == `BURST_W'(0)) ? `BURST_ONE : bus.burstCount;
    assign mapped   = (beatAddr < `MAP_TOP);
    assign romHit   = (beatAddr >= `ROM_BASE) && mapped;

    // Status of the beat on the bus; only a clean beat touches memory
    always_comb begin
        beatStatus = `RESP_OK;
        beatOk     = 1'b0;
        if (!mapped) begin
            beatStatus = `RESP_DECERR;
        end else if (!legalBe || (romHit && !bus.debugAccess)) begin
            beatStatus = `RESP_SLVERR;
        end else begin
            beatOk = 1'b1;
        end
    end

    // Write merges only enabled lanes; others keep their old byte
    always_comb begin
        memWord = mem[beatAddr];
        for (int i = 0; i < `BE_W; i++) begin
            if (bus.byteEnable[i]) begin
                memWord[i*8 +: 8] = bus.writeData[i*8 +: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state   = state;
        next_addr    = addr;
        next_left    = left;
        next_wStatus = wStatus;
        memWe        = 1'b0;
        case (state)
            S_IDLE: begin
                if (bus.read) begin
                    next_state = S_READ;
                    next_addr  = bus.address;
                    next_left  = beats;
                end else if (bus.write) begin
                    // First beat rides on the command cycle
                    next_addr    = beatAddr + `ADDR_W'(1);
                    next_left    = beats - `BURST_ONE;
                    next_wStatus = beatStatus;
                    memWe        = beatOk;
                    if (beats == `BURST_ONE) begin
                        next_state = S_WRESP;
                    end else begin
                        next_state = S_WRITE;
                    end
                end
            end
            S_READ: begin
                // Every word answered even when unmapped
                next_addr = addr + `ADDR_W'(1);
                next_left = left - `BURST_ONE;
                if (left == `BURST_ONE) begin
                    next_state = S_IDLE;
                end
            end
            S_WRITE: begin
                if (bus.write) begin
                    // Any failed beat marks the whole burst
                    if (beatStatus != `RESP_OK) begin
                        next_wStatus = beatStatus;
                    end
                    memWe     = beatOk;
                    next_addr = addr + `ADDR_W'(1);
                    next_left = left - `BURST_ONE;
                    if (left == `BURST_ONE) begin
                        next_state = S_WRESP;
                    end
                end
            end
            S_WRESP: begin
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Answer registers; one word or one write status per cycle
    always_comb begin
        next_rData  = rData;
        next_rValid = 1'b0;
        next_wValid = 1'b0;
        next_resp   = `RESP_OK;
        case (state)
            S_READ: begin
                // Status per word, zero data when unmapped
                next_rValid = 1'b1;
                next_rData  = mapped ? mem[addr] : `DATA_W'(0);
                next_resp   = mapped ? `RESP_OK : `RESP_DECERR;
            end
            S_WRESP: begin
                // Single response, never alongside read data
                next_wValid = 1'b1;
                next_resp   = wStatus;
            end
            default: begin
                next_rValid = 1'b0;
            end
        endcase
    end

    // Accept the command cycle, then stream
    assign bus.waitRequest        = (state != S_IDLE) && (state != S_WRITE);
    assign bus.readData           = rData;
    assign bus.readDataValid      = rValid;
    assign bus.writeResponseValid = wValid;
    assign bus.response           = resp;

    ////////////////////////////////////////////////////////////////////
    // Command and burst tracking
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state   <= S_IDLE;
            addr    <= `ADDR_W'(0);
            left    <= `BURST_W'(0);
            wStatus <= `RESP_OK;
        end else begin
            state   <= next_state;
            addr    <= next_addr;
            left    <= next_left;
            wStatus <= next_wStatus;
        end
    end

    // Answer outputs straight from flip-flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rData   <= `DATA_W'(0);
            rValid  <= 1'b0;
            wValid  <= 1'b0;
            resp    <= `RESP_OK;
        end else begin
            rData   <= next_rData;
            rValid  <= next_rValid;
            wValid  <= next_wValid;
            resp    <= next_resp;
        end
    end

    // Memory has no reset, contents undefined at start
    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[beatAddr] <= memWord;
        end
    end
endmodule

// ==== src/mm_request_master.sv ====
// Requesting end: issues single or burst commands and gathers answers
`include "mm_link_defs.svh"
module mm_request_master
    import mm_link_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                reqValid,
    input  wire logic                reqWrite,
    input  wire logic [`ADDR_W-1:0]  reqAddr,
    input  wire logic [`BURST_W-1:0] reqBurst,
    input  wire logic [`BE_W-1:0]    reqBe,
    input  wire logic                reqDebug,
    input  wire logic [`DATA_W-1:0]  wrData,
    output logic                     wrTaken,
    output logic                     reqReady,
    output logic                     rdValid,
    output logic [`DATA_W-1:0]       rdData,
    output logic                     rdError,
    output logic                     wrDone,
    output logic [1:0]               wrStatus,
    mm_link_if.master                bus
);
    ////////////////////////////////////////////////////////////////////
    mst_state_t          state, next_state;
    logic [`BURST_W-1:0] left,  next_left;
    logic                isWr,  next_isWr;
    logic [`ADDR_W-1:0]  addr,  next_addr;
    logic [`BE_W-1:0]    be,    next_be;
    logic                dbg,   next_dbg;
    logic [`DATA_W-1:0]  rdD,   next_rdD;
    logic                rdV,   next_rdV;
    logic                rdE,   next_rdE;
    logic                wD,    next_wD;
    resp_t               wS,    next_wS;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_left  = left;
        next_isWr  = isWr;
        next_addr  = addr;
        next_be    = be;
        next_dbg   = dbg;
        next_rdD   = rdD;
        next_rdV   = 1'b0;
        next_rdE   = 1'b0;
        next_wD    = 1'b0;
        next_wS    = wS;
        case (state)
            M_IDLE: begin
                if (reqValid && !bus.waitRequest) begin
                    next_isWr  = reqWrite;
                    next_addr  = reqAddr;
                    next_be    = (reqBe == `BE_NONE) ? `BE_ALL : reqBe;
                    next_dbg   = reqDebug;
                    next_left  = (reqBurst == `BURST_W'(0)) ? `BURST_ONE : reqBurst;
                    next_state = reqWrite ? M_WWAIT : M_RWAIT;
                end
            end
            M_RWAIT: begin
                if (bus.readDataValid) begin
                    next_rdV  = 1'b1;
                    next_rdE  = (bus.response != `RESP_OK);
                    // Errored word is unreliable, pass zeros
                    next_rdD  = (bus.response == `RESP_OK) ? bus.readData : `DATA_W'(0);
                    next_left = left - `BURST_ONE;
                    if (left == `BURST_ONE) begin
                        next_state = M_IDLE;
                    end
                end
            end
            M_WWAIT: begin
                if (bus.writeResponseValid) begin
                    next_wD    = 1'b1;
                    next_wS    = bus.response;
                    next_state = M_IDLE;
                end else if (left != `BURST_W'(0)) begin
                    next_left = left - `BURST_ONE;
                end
            end
            default: next_state = M_IDLE;
        endcase
    end

    // Command cycle from the request, later beats from the held command
    assign bus.read        = (state == M_IDLE) ? (reqValid && !reqWrite) : 1'b0;
    assign bus.write       = (state == M_IDLE) ? (reqValid && reqWrite)
                                               : (state == M_WWAIT && isWr && left > `BURST_ONE);
    assign bus.address     = (state == M_IDLE) ? reqAddr : addr;
    assign bus.burstCount  = (state == M_IDLE) ? reqBurst : left;
    assign bus.byteEnable  = (state == M_IDLE) ? ((reqBe == `BE_NONE) ? `BE_ALL : reqBe) : be;
    assign bus.writeData   = wrData;
    assign bus.debugAccess = (state == M_IDLE) ? reqDebug : dbg;
    assign wrTaken         = bus.write && !bus.waitRequest;
    assign reqReady        = (state == M_IDLE) && !bus.waitRequest;
    assign rdValid         = rdV;
    assign rdData          = rdD;
    assign rdError         = rdE;
    assign wrDone          = wD;
    assign wrStatus        = wS;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= M_IDLE;
            left  <= `BURST_W'(0);
            isWr  <= 1'b0;
            addr  <= `ADDR_W'(0);
            be    <= `BE_ALL;
            dbg   <= 1'b0;
            rdD   <= `DATA_W'(0);
            rdV   <= 1'b0;
            rdE   <= 1'b0;
            wD    <= 1'b0;
            wS    <= `RESP_OK;
        end else begin
            state <= next_state;
            left  <= next_left;
            isWr  <= next_isWr;
            addr  <= next_addr;
            be    <= next_be;
            dbg   <= next_dbg;
            rdD   <= next_rdD;
            rdV   <= next_rdV;
            rdE   <= next_rdE;
            wD    <= next_wD;
            wS    <= next_wS;
        end
    end
endmodule

// ==== bench/mm_link_monitor.sv ====
// Checker on the link signals between the two ends
`include "mm_link_defs.svh"
module mm_link_monitor (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                read,
    input wire logic                write,
    input wire logic                waitRequest,
    input wire logic                readDataValid,
    input wire logic                writeResponseValid,
    input wire logic [`BURST_W-1:0] burstCount,
    input wire logic [1:0]          response
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    // Words still owed; zero burst counts as one beat
    logic [8:0] pending;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            pending <= 9'h000;
        else if (read && !waitRequest)
            pending <= (burstCount == 8'h00) ? 9'h001 : {1'b0, burstCount};
        else if (readDataValid)
            pending <= pending - 9'h001;
    end
    ////////////////////////////////////////////////////////////////
    chk_shared_channel: assert property (!(readDataValid && writeResponseValid))
        else $error("read and write response in one cycle");
    chk_no_reserved: assert property (response != 2'h1)
        else $error("reserved response driven");
    chk_resp_idle: assert property (!(readDataValid || writeResponseValid) |-> response == 2'h0)
        else $error("response not zero outside valid cycles");
    chk_read_answer: assert property (read && !waitRequest |-> ##2 readDataValid)
        else $error("read word not two cycles after command");
    chk_read_hold: assert property (read && !waitRequest |=> waitRequest)
        else $error("wait not raised after read command");
    chk_read_extra: assert property (readDataValid |-> pending != 9'h000)
        else $error("more read words than burst");
    chk_read_stream: assert property (readDataValid && pending > 9'h001 |=> readDataValid)
        else $error("read burst words not back to back");
    chk_wresp_time: assert property ((write && !waitRequest) ##1 !write |-> waitRequest ##1 writeResponseValid)
        else $error("write response not after last beat");
    chk_wresp_cause: assert property (writeResponseValid |-> $past(write, 2) && !$past(waitRequest, 2))
        else $error("write response without taken beat");
    cover property (readDataValid ##1 readDataValid);
    cover property (writeResponseValid && response == 2'h2);
    cover property (readDataValid && response == 2'h3);
endmodule

// ==== bench/mm_slave_transfer_response_test.sv ====
// Testbench joining both ends of the transfer link
`include "mm_link_defs.svh"
module mm_slave_transfer_response_test;
    import mm_link_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, reqValid, reqWrite, reqDebug, wrTaken, reqReady, rdValid, rdError, wrDone;
    logic [7:0]  reqAddr, reqBurst;
    logic [3:0]  reqBe;
    logic [31:0] wrData, rdData;
    logic [1:0]  wrStatus;
    logic [3:0]  flags;
    logic [31:0] shadow [256];
    logic [31:0] wq [$];
    int          errors = 0;
    int          check_count = 0;
    assign flags = {wrDone, rdValid, wrTaken, reqReady};
    mm_link_if link ();
    mm_request_master i_mm_request_master (.clk(clk), .sys_rst(sys_rst), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqBurst(reqBurst), .reqBe(reqBe), .reqDebug(reqDebug),
        .wrData(wrData), .wrTaken(wrTaken), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
        .rdError(rdError), .wrDone(wrDone), .wrStatus(wrStatus), .bus(link.master));
    mm_memory_slave i_mm_memory_slave (.clk(clk), .sys_rst(sys_rst), .bus(link.slave));
    mm_link_monitor i_mm_link_monitor (.clk(clk), .sys_rst(sys_rst), .read(link.read), .write(link.write),
        .waitRequest(link.waitRequest), .readDataValid(link.readDataValid),
        .writeResponseValid(link.writeResponseValid), .burstCount(link.burstCount), .response(link.response));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Checks before waiting, so a flag already high is not missed
    task automatic wait_for(input int b);
        for (int k = 0; k < 40; k++) begin
            if (flags[b] === 1'b1) return;
            @(negedge clk);
        end
        errors++;
        $display("MISMATCH flag %0d expected 1 seen 0", b);
    endtask
    task automatic do_write(input logic [7:0] a, input logic [3:0] be, input logic dbg, input logic [1:0] st);
        int n;
        n = wq.size();
        @(posedge clk);
        {reqValid, reqWrite, reqAddr, reqBurst, reqBe, reqDebug} <= {2'b11, a, n[7:0], be, dbg};
        wrData <= wq[0];
        @(negedge clk);
        wait_for(0);
        for (int i = 0; i < n; i++) begin
            wait_for(1);
            @(posedge clk);
            reqValid <= 1'b0;
            if (i + 1 < n) wrData <= wq[i + 1];
            if (st == 2'h0)
                for (int j = 0; j < 4; j++) if (be[j]) shadow[a + i[7:0]][8*j +: 8] = wq[i][8*j +: 8];
            @(negedge clk);
        end
        wait_for(3);
        check("wrStatus", {30'h0, wrStatus}, {30'h0, st});
    endtask
    task automatic do_read(input logic [7:0] a, input int n);
        logic [7:0] ad;
        @(posedge clk);
        {reqValid, reqWrite, reqAddr, reqBurst, reqBe, reqDebug} <= {2'b10, a, n[7:0], 5'h1e};
        @(negedge clk);
        wait_for(0);
        @(posedge clk);
        reqValid <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            wait_for(2);
            ad = a + i[7:0];
            check("rdError", {31'h0, rdError}, {31'h0, ad >= `MAP_TOP});
            check("rdData", rdData, (ad >= `MAP_TOP) ? 32'h0 : shadow[ad]);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_lanes();
        logic [3:0] pat [8] = '{4'hf, 4'h3, 4'hc, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
        for (int k = 0; k < 8; k++) begin
            wq = '{32'h11223344 ^ (k * 32'h01010101)};
            do_write(8'h0a, pat[k], 1'b0, (k == 7) ? 2'h2 : 2'h0);
            do_read(8'h0a, 1);
        end
    endtask
    task automatic t_burst();
        wq = '{32'ha0a1a2a3, 32'hb0b1b2b3, 32'hc0c1c2c3, 32'hd0d1d2d3};
        do_write(8'h20, 4'hf, 1'b0, 2'h0);
        wq = '{32'h5555aaaa, 32'h6666bbbb};
        do_write(8'h21, 4'hc, 1'b0, 2'h0);
        do_read(8'h20, 4);
    endtask
    task automatic t_debug();
        wq = '{32'hdeadbeef};
        do_write(8'hee, 4'hf, 1'b0, 2'h2);
        wq = '{32'h0badf00d, 32'h12345678};
        do_write(8'hee, 4'hf, 1'b1, 2'h0);
        do_read(8'hee, 2);
    endtask
    task automatic t_map();
        wq = '{32'hcafe0001};
        do_write(8'hf5, 4'hf, 1'b0, 2'h3);
        do_read(8'hee, 4);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs a little over a hundred cycles
    initial begin
        #50000;
        errors++;
        print_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        {reqValid, reqWrite, reqDebug, reqAddr, reqBurst, reqBe, wrData} = '0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_lanes();
        t_burst();
        t_debug();
        t_map();
        print_verdict();
    end
endmodule
